// File: inc/pms_pkg.sv
package pms_pkg;

    localparam int unsigned PMS_AW    = 8;
    localparam int unsigned PMS_DW    = 32;
    localparam int unsigned PMS_TMO_W = 32;
    localparam int unsigned PMS_LP_W  = 16;
    localparam int unsigned PMS_CTRL_W = 3;
    localparam int unsigned PMS_IRQ_W  = 3;
    localparam int unsigned PMS_RF_W   = 4;
    localparam int unsigned PMS_SYNC_W = 3;

    // Register byte offsets
    localparam logic [PMS_AW-1:0] PMS_OFS_CTRL      = 8'h00;
    localparam logic [PMS_AW-1:0] PMS_OFS_TMO_IDLE  = 8'h04;
    localparam logic [PMS_AW-1:0] PMS_OFS_TMO_SLEEP = 8'h08;
    localparam logic [PMS_AW-1:0] PMS_OFS_TMO_OFF   = 8'h0C;
    localparam logic [PMS_AW-1:0] PMS_OFS_LP_IVL    = 8'h10;
    localparam logic [PMS_AW-1:0] PMS_OFS_STATUS    = 8'h14;
    localparam logic [PMS_AW-1:0] PMS_OFS_IRQ_STAT  = 8'h18;
    localparam logic [PMS_AW-1:0] PMS_OFS_IRQ_CLR   = 8'h1C;
    localparam logic [PMS_AW-1:0] PMS_OFS_IRQ_EN    = 8'h20;
    localparam logic [PMS_AW-1:0] PMS_OFS_RF_FORCE  = 8'h24;
    localparam logic [PMS_AW-1:0] PMS_OFS_CMD       = 8'h28;
    localparam logic [PMS_AW-1:0] PMS_OFS_TIMER     = 8'h2C;

    // Control bits
    localparam int unsigned PMS_CTRL_AUTO   = 0;
    localparam int unsigned PMS_CTRL_REGOFF = 1;
    localparam int unsigned PMS_CTRL_LPCONN = 2;
    localparam logic [PMS_CTRL_W-1:0] PMS_CTRL_RST = 3'h3;

    // Command bits
    localparam int unsigned PMS_CMD_WAKE = 0;
    localparam int unsigned PMS_CMD_STEP = 1;

    // Interrupt bits
    localparam int unsigned PMS_IRQ_MODE   = 0;
    localparam int unsigned PMS_IRQ_HWAKE  = 1;
    localparam int unsigned PMS_IRQ_LPWAKE = 2;

    // Status field position of mode
    localparam int unsigned PMS_STAT_MODE_LSB = 0;

    localparam logic [PMS_TMO_W-1:0] PMS_TMO_IDLE_RST  = 32'h0000_C350;
    localparam logic [PMS_TMO_W-1:0] PMS_TMO_SLEEP_RST = 32'h0004_C4B4;
    localparam logic [PMS_TMO_W-1:0] PMS_TMO_OFF_RST   = 32'h02FA_F080;
    localparam logic [PMS_LP_W-1:0]  PMS_LP_IVL_RST    = 16'h0800;

    localparam int unsigned PMS_HTRANS_ACT_BIT = 1;
    localparam logic        PMS_HRESP_OKAY     = 1'b0;

    typedef enum logic [1:0] {
        PMS_ACTIVE,
        PMS_IDLE,
        PMS_SLEEP,
        PMS_OFF
    } pms_mode_t;

    typedef struct packed {
        logic tx;
        logic rx;
        logic pll;
        logic pa;
    } pms_rf_t;

    typedef struct packed {
        pms_mode_t             mode;
        logic [PMS_TMO_W-1:0]  tmr;
        logic [PMS_LP_W-1:0]   lp_cnt;
        logic [PMS_SYNC_W-1:0] ue_sync;
        logic [PMS_SYNC_W-1:0] lp_sync;
        logic                  ue_lvl;
        logic                  lp_lvl;
        logic [PMS_CTRL_W-1:0] ctrl;
        logic [PMS_TMO_W-1:0]  tmo_idle;
        logic [PMS_TMO_W-1:0]  tmo_sleep;
        logic [PMS_TMO_W-1:0]  tmo_off;
        logic [PMS_LP_W-1:0]   lp_ivl;
        logic [PMS_IRQ_W-1:0]  irq_stat;
        logic [PMS_IRQ_W-1:0]  irq_en;
        pms_rf_t               rf_force;
        logic                  wr_pend;
        logic                  rd_pend;
        logic [PMS_AW-1:0]     addr;
        logic                  hreadyout;
        logic [PMS_DW-1:0]     hrdata;
        logic                  core_en;
        logic                  amp_en;
        logic                  reg_dis;
        pms_rf_t               rf_pd;
        logic                  wake_tick;
        logic                  irq;
    } pms_state_t;

    localparam pms_rf_t PMS_RF_ALL = '{tx: 1'b1, rx: 1'b1, pll: 1'b1, pa: 1'b1};

    localparam pms_state_t PMS_STATE_RST = '{
        mode:      PMS_ACTIVE,
        ctrl:      PMS_CTRL_RST,
        tmo_idle:  PMS_TMO_IDLE_RST,
        tmo_sleep: PMS_TMO_SLEEP_RST,
        tmo_off:   PMS_TMO_OFF_RST,
        lp_ivl:    PMS_LP_IVL_RST,
        hreadyout: 1'b1,
        core_en:   1'b1,
        amp_en:    1'b1,
        rf_pd:     PMS_RF_ALL,
        default:   '0
    };

endpackage

// File: hw/pms_power_mode_sequencer.sv
// Summary of operation
// - Four power modes exist, from highest to lowest: active, idle, sleep and deep power-off.
// - After a programmed period without user activity the mode steps to the next lower one.
// - User activity in any lower mode returns straight to active without intermediate modes.
// - Deep power-off turns off both the core supply output and the amplifier supply.
// - The always-on I/O domain logic keeps watching for user events in deep power-off and powers the chip back up.
// - Separate power-down outputs exist for the radio transmit path, receive path, synthesizer and amplifier.
// - Baseband packet requests switch the radio blocks on and off within each packet exchange.
// - In low-power connection mode the block counts low-power oscillator ticks while in sleep and wakes after a set interval.
// - Power actions come from software register writes, baseband packet events, user events, activity timeouts or the low-power interval.
// - Entering deep power-off drives a firmware-enabled signal that disables the on-chip regulator.
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
module pms_power_mode_sequencer
    import pms_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              clk_en,
    input  wire logic              hsel,
    input  wire logic [PMS_DW-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [PMS_DW-1:0] hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [PMS_DW-1:0]      hrdata,
    input  wire logic              user_event,
    input  wire logic              lp_osc,
    input  wire logic              bb_tx_req,
    input  wire logic              bb_rx_req,
    output pms_mode_t              mode,
    output logic                   core_supply_output_en,
    output logic                   amplifier_supply_en,
    output logic                   regulator_disable,
    output pms_rf_t                rf_pd,
    output logic                   lp_wake_tick,
    output logic                   irq
);

    pms_state_t st_r;
    pms_state_t st_nxt;

    function automatic pms_mode_t lower_mode(input pms_mode_t m);
        unique case (m)
            PMS_ACTIVE: lower_mode = PMS_IDLE;
            PMS_IDLE:   lower_mode = PMS_SLEEP;
            PMS_SLEEP:  lower_mode = PMS_OFF;
            PMS_OFF:    lower_mode = PMS_OFF;
        endcase
    endfunction

    function automatic logic [PMS_TMO_W-1:0] mode_period(input pms_state_t s);
        unique case (s.mode)
            PMS_ACTIVE: mode_period = s.tmo_idle;
            PMS_IDLE:   mode_period = s.tmo_sleep;
            PMS_SLEEP:  mode_period = s.tmo_off;
            PMS_OFF:    mode_period = '0;
        endcase
    endfunction

    function automatic logic [PMS_DW-1:0] read_word(input pms_state_t s);
        logic [PMS_DW-1:0] w;
        w = '0;
        unique case (s.addr)
            PMS_OFS_CTRL:      w[PMS_CTRL_W-1:0] = s.ctrl;
            PMS_OFS_TMO_IDLE:  w = s.tmo_idle;
            PMS_OFS_TMO_SLEEP: w = s.tmo_sleep;
            PMS_OFS_TMO_OFF:   w = s.tmo_off;
            PMS_OFS_LP_IVL:    w[PMS_LP_W-1:0] = s.lp_ivl;
            PMS_OFS_STATUS:    w[PMS_STAT_MODE_LSB +: $bits(pms_mode_t)] = s.mode;
            PMS_OFS_IRQ_STAT:  w[PMS_IRQ_W-1:0] = s.irq_stat;
            PMS_OFS_IRQ_EN:    w[PMS_IRQ_W-1:0] = s.irq_en;
            PMS_OFS_RF_FORCE:  w[PMS_RF_W-1:0] = s.rf_force;
            PMS_OFS_TIMER:     w = s.tmr;
            default:           w = '0;
        endcase
        return w;
    endfunction

    // Three-stage synchroniser with agreement filter; stage 0 feeds stage 1 only
    function automatic logic sync_level(input logic [PMS_SYNC_W-1:0] s, input logic lvl);
        return (s[1] == s[2]) ? s[2] : lvl;
    endfunction

    always_comb begin
        logic              ue_rise;
        logic              lp_tick;
        logic              bb_evt;
        logic              addr_ok;
        logic              cmd_wake;
        logic              cmd_step;
        logic              lp_wake;
        logic              timeout;
        logic              powered;
        logic              tx_on;
        logic              rx_on;
        logic [PMS_TMO_W-1:0] period;
        logic [PMS_IRQ_W-1:0] clr;
        logic [PMS_IRQ_W-1:0] ev;
        ue_rise  = 1'b0;
        lp_tick  = 1'b0;
        bb_evt   = 1'b0;
        addr_ok  = 1'b0;
        cmd_wake = 1'b0;
        cmd_step = 1'b0;
        lp_wake  = 1'b0;
        timeout  = 1'b0;
        powered  = 1'b0;
        tx_on    = 1'b0;
        rx_on    = 1'b0;
        period   = '0;
        clr      = '0;
        ev       = '0;
        st_nxt   = st_r;
        st_nxt.wake_tick = 1'b0;

        // Always-on domain: keeps sampling wake sources in every mode
        st_nxt.ue_sync = {st_r.ue_sync[PMS_SYNC_W-2:0], user_event};
        st_nxt.lp_sync = {st_r.lp_sync[PMS_SYNC_W-2:0], lp_osc};
        st_nxt.ue_lvl  = sync_level(st_r.ue_sync, st_r.ue_lvl);
        st_nxt.lp_lvl  = sync_level(st_r.lp_sync, st_r.lp_lvl);
        ue_rise = st_nxt.ue_lvl & ~st_r.ue_lvl;
        lp_tick = st_nxt.lp_lvl & ~st_r.lp_lvl;

        // Register writes land in the data phase
        if (st_r.wr_pend) begin
            unique case (st_r.addr)
                PMS_OFS_CTRL:      st_nxt.ctrl = hwdata[PMS_CTRL_W-1:0];
                PMS_OFS_TMO_IDLE:  st_nxt.tmo_idle = hwdata;
                PMS_OFS_TMO_SLEEP: st_nxt.tmo_sleep = hwdata;
                PMS_OFS_TMO_OFF:   st_nxt.tmo_off = hwdata;
                PMS_OFS_LP_IVL:    st_nxt.lp_ivl = hwdata[PMS_LP_W-1:0];
                PMS_OFS_IRQ_CLR:   clr = hwdata[PMS_IRQ_W-1:0];
                PMS_OFS_IRQ_EN:    st_nxt.irq_en = hwdata[PMS_IRQ_W-1:0];
                PMS_OFS_RF_FORCE:  st_nxt.rf_force = hwdata[PMS_RF_W-1:0];
                PMS_OFS_CMD: begin
                    cmd_wake = hwdata[PMS_CMD_WAKE];
                    cmd_step = hwdata[PMS_CMD_STEP];
                end
                default: ;
            endcase
        end

        // Baseband is unpowered in deep power-off, so its requests are ignored there
        bb_evt = (bb_tx_req | bb_rx_req) & (st_r.mode != PMS_OFF);

        if (st_r.ctrl[PMS_CTRL_LPCONN] && st_r.mode == PMS_SLEEP) begin
            if (lp_tick) begin
                if (st_r.lp_cnt >= st_r.lp_ivl - 16'h0001) begin
                    lp_wake = 1'b1;
                    st_nxt.lp_cnt = '0;
                end else begin
                    st_nxt.lp_cnt = st_r.lp_cnt + 16'h0001;
                end
            end
        end else begin
            st_nxt.lp_cnt = '0;
        end

        period  = mode_period(st_r);
        timeout = st_r.ctrl[PMS_CTRL_AUTO] && period != '0 && st_r.tmr >= period - 32'h0000_0001;

        if (ue_rise || cmd_wake || lp_wake || bb_evt) begin
            st_nxt.mode = PMS_ACTIVE;
            st_nxt.tmr  = '0;
        end else if ((cmd_step || timeout) && st_r.mode != PMS_OFF) begin
            st_nxt.mode = lower_mode(st_r.mode);
            st_nxt.tmr  = '0;
        end else if (st_r.ctrl[PMS_CTRL_AUTO] && st_r.mode != PMS_OFF) begin
            st_nxt.tmr = st_r.tmr + 32'h0000_0001;
        end

        st_nxt.wake_tick = lp_wake;

        ev[PMS_IRQ_MODE]   = st_nxt.mode != st_r.mode;
        ev[PMS_IRQ_HWAKE]  = ue_rise && st_r.mode == PMS_OFF;
        ev[PMS_IRQ_LPWAKE] = lp_wake;
        // New event wins over a clear in the same cycle
        st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
        st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_en);

        // Supplies follow the mode being entered
        powered = st_nxt.mode != PMS_OFF;
        st_nxt.core_en = powered;
        st_nxt.amp_en  = powered;
        st_nxt.reg_dis = ~powered & st_r.ctrl[PMS_CTRL_REGOFF];

        // Radio blocks powered only for the packet in flight, or by software force
        tx_on = powered & (bb_tx_req | st_r.rf_force.tx);
        rx_on = powered & (bb_rx_req | st_r.rf_force.rx);
        st_nxt.rf_pd.tx  = ~tx_on;
        st_nxt.rf_pd.rx  = ~rx_on;
        st_nxt.rf_pd.pll = ~(tx_on | rx_on | (powered & st_r.rf_force.pll));
        st_nxt.rf_pd.pa  = ~(powered & (bb_tx_req | st_r.rf_force.pa));

        // AHB-Lite slave: writes zero-wait, reads take one wait state
        addr_ok = hsel & htrans[PMS_HTRANS_ACT_BIT] & hready;
        st_nxt.wr_pend = addr_ok & hwrite;
        st_nxt.rd_pend = addr_ok & ~hwrite;
        if (addr_ok) begin
            st_nxt.addr = haddr[PMS_AW-1:0];
        end
        if (addr_ok && !hwrite) begin
            st_nxt.hreadyout = 1'b0;
        end else if (st_r.rd_pend) begin
            // Sampled one cycle late so a write just before is already visible
            st_nxt.hrdata    = read_word(st_r);
            st_nxt.hreadyout = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= PMS_STATE_RST;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign hreadyout             = st_r.hreadyout;
    assign hresp                 = PMS_HRESP_OKAY;
    assign hrdata                = st_r.hrdata;
    assign mode                  = st_r.mode;
    assign core_supply_output_en = st_r.core_en;
    assign amplifier_supply_en   = st_r.amp_en;
    assign regulator_disable     = st_r.reg_dis;
    assign rf_pd                 = st_r.rf_pd;
    assign lp_wake_tick          = st_r.wake_tick;
    assign irq                   = st_r.irq;

endmodule

// File: tb/pms_power_mode_sequencer_props.sv
module pms_power_mode_sequencer_props
    import pms_pkg::*;
(
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       clk_en,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       bb_tx_req,
    input wire logic       bb_rx_req,
    input wire pms_mode_t  mode,
    input wire logic       core_supply_output_en,
    input wire logic       amplifier_supply_en,
    input wire logic       regulator_disable,
    input wire pms_rf_t    rf_pd,
    input wire logic       lp_wake_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_off_supply_cut: assert property (mode == PMS_OFF |-> !core_supply_output_en && !amplifier_supply_en)
        else $error("supplies on in deep power-off");
    a_on_supply_up: assert property (mode != PMS_OFF |-> core_supply_output_en && amplifier_supply_en)
        else $error("supplies off outside deep power-off");
    a_regoff_only_off: assert property (regulator_disable |-> mode == PMS_OFF)
        else $error("regulator disabled outside deep power-off");
    a_off_rf_down: assert property (mode == PMS_OFF |-> rf_pd == PMS_RF_ALL)
        else $error("radio block powered in deep power-off");
    a_step_one_lower: assert property (($changed(mode) && mode != PMS_ACTIVE) |-> mode == $past(mode) + 2'd1)
        else $error("mode dropped by other than one step");
    a_tx_path_up: assert property ((clk_en && bb_tx_req && mode != PMS_OFF) |=> !rf_pd.tx && !rf_pd.pa && !rf_pd.pll)
        else $error("transmit path not powered for packet");
    a_rx_path_up: assert property ((clk_en && bb_rx_req && mode != PMS_OFF) |=> !rf_pd.rx && !rf_pd.pll)
        else $error("receive path not powered for packet");
    a_bb_wakes: assert property ((clk_en && (bb_tx_req || bb_rx_req) && mode != PMS_OFF) |=> mode == PMS_ACTIVE)
        else $error("packet event did not wake to active");
    a_lp_wake_active: assert property (lp_wake_tick |-> mode == PMS_ACTIVE && $past(mode) == PMS_SLEEP)
        else $error("interval wake not from sleep to active");
    a_read_wait: assert property ((clk_en && hsel && htrans[1] && !hwrite && hready) |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait state");
    a_resp_okay: assert property (hresp == PMS_HRESP_OKAY)
        else $error("response not okay");
endmodule

bind pms_power_mode_sequencer pms_power_mode_sequencer_props i_props (.hclk, .hresetn, .clk_en, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .bb_tx_req, .bb_rx_req, .mode, .core_supply_output_en,
    .amplifier_supply_en, .regulator_disable, .rf_pd, .lp_wake_tick);

// File: tb/pms_rail_model.sv
module pms_rail_model
    import pms_pkg::*;
(
    input  wire logic    core_supply_output_en,
    input  wire logic    amplifier_supply_en,
    input  wire logic    regulator_disable,
    input  wire pms_rf_t rf_pd,
    output logic         core_up,
    output logic [3:0]   radio_live
);
    timeunit 1ns;
    timeprecision 1ns;
    // Regulator cut drops the rail even if the enable were left high
    assign core_up = core_supply_output_en && !regulator_disable;
    assign radio_live = ~rf_pd & {4{core_up && amplifier_supply_en}};
endmodule

// File: tb/pms_power_mode_sequencer_tb.sv
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

module pms_power_mode_sequencer_tb
    import pms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp, user_event, lp_osc = 1'b0;
    logic bb_tx_req, bb_rx_req, core_supply_output_en, amplifier_supply_en, regulator_disable;
    logic lp_wake_tick, irq, core_up, rd_ph = 1'b0, snap_req = 1'b0, lp_run = 1'b0;
    logic [31:0] haddr, hwdata, hrdata, e_m, tmo;
    logic [1:0] htrans;
    logic [2:0] hsize, lp_cnt = 3'h0;
    logic [3:0] radio_live;
    pms_mode_t mode;
    pms_rf_t rf_pd;
    logic [31:0] exp_q[$];
    int num_errors = 0;
    int n_compared = 0;
    int n_lpw = 0;

    always #10 hclk = ~hclk;
    assign hready = hreadyout;

    pms_power_mode_sequencer i_dut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hresp, .hrdata, .user_event, .lp_osc, .bb_tx_req, .bb_rx_req, .mode,
        .core_supply_output_en, .amplifier_supply_en, .regulator_disable, .rf_pd, .lp_wake_tick, .irq);
    pms_rail_model i_rail (.core_supply_output_en, .amplifier_supply_en, .regulator_disable, .rf_pd,
        .core_up, .radio_live);

    // Slow oscillator only runs while a scenario asks for it
    always @(posedge hclk) begin
        lp_cnt <= lp_run ? lp_cnt + 3'h1 : 3'h0;
        lp_osc <= lp_run && lp_cnt[2];
    end

    // Counts interval wake pulses for the closing check
    always @(posedge hclk) begin
        if (lp_wake_tick === 1'b1)
            n_lpw++;
    end

    always @(posedge hclk) begin
        if (rd_ph && hready === 1'b1) begin
            e_m = exp_q.pop_front();
            `CHK("hrdata", e_m, hrdata)
            rd_ph = 1'b0;
        end
        if (hsel && htrans[1] && !hwrite && hready === 1'b1)
            rd_ph = 1'b1;
    end

    always @(negedge hclk) begin
        if (snap_req) begin
            e_m = exp_q.pop_front();
            `CHK("ports", e_m, {17'h0, radio_live, irq, regulator_disable, amplifier_supply_en,
                core_supply_output_en, core_up, rf_pd, mode})
            snap_req = 1'b0;
        end
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // Extra edge lets registered outputs catch up with the last write
    task automatic snap(input pms_mode_t m, input logic sup, input logic rg, input logic [3:0] rf, input logic ir);
        @(posedge hclk);
        exp_q.push_back({17'h0, ~rf & {4{sup}}, ir, rg, sup, sup, sup, rf, m});
        snap_req = 1'b1;
        wait (snap_req == 1'b0);
        @(posedge hclk);
    endtask

    task automatic ue_pulse;
        user_event <= 1'b1;
        repeat (4) @(posedge hclk);
        user_event <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask

    task automatic wait_mode(input pms_mode_t m);
        for (int i = 0; i < 400 && mode !== m; i++) @(posedge hclk);
    endtask

    task automatic results;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        results();
    end

    initial begin
        {hresetn, hsel, hwrite, user_event, bb_tx_req, bb_rx_req, htrans} = '0;
        {haddr, hwdata} = '0;
        clk_en = 1'b1;
        hsize = 3'h2;
        void'($urandom(79573));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(PMS_OFS_CTRL, {29'h0, PMS_CTRL_RST});
        rd(PMS_OFS_TMO_OFF, PMS_TMO_OFF_RST);
        rd(PMS_OFS_LP_IVL, {16'h0, PMS_LP_IVL_RST});
        rd(8'h30, 32'h0);
        snap(PMS_ACTIVE, 1'b1, 1'b0, 4'hF, 1'b0);
        tmo = 32'd12 + ($urandom % 4);
        wr(PMS_OFS_TMO_IDLE, tmo);
        wr(PMS_OFS_TMO_SLEEP, tmo);
        wr(PMS_OFS_TMO_OFF, tmo);
        repeat (5) ue_pulse;
        snap(PMS_ACTIVE, 1'b1, 1'b0, 4'hF, 1'b0);
        wr(PMS_OFS_IRQ_EN, 32'h7);
        wait_mode(PMS_OFF);
        snap(PMS_OFF, 1'b0, 1'b1, 4'hF, 1'b1);
        rd(PMS_OFS_IRQ_STAT, 32'h1);
        bb_tx_req <= 1'b1;
        snap(PMS_OFF, 1'b0, 1'b1, 4'hF, 1'b1);
        bb_tx_req <= 1'b0;
        wr(PMS_OFS_CMD, 32'h2);
        rd(PMS_OFS_STATUS, 32'h3);
        wr(PMS_OFS_CTRL, 32'h2);
        ue_pulse();
        wait_mode(PMS_ACTIVE);
        snap(PMS_ACTIVE, 1'b1, 1'b0, 4'hF, 1'b1);
        rd(PMS_OFS_IRQ_STAT, 32'h3);
        wr(PMS_OFS_IRQ_EN, 32'h0);
        snap(PMS_ACTIVE, 1'b1, 1'b0, 4'hF, 1'b0);
        wr(PMS_OFS_IRQ_EN, 32'h7);
        wr(PMS_OFS_IRQ_CLR, 32'h3);
        rd(PMS_OFS_IRQ_STAT, 32'h0);
        bb_tx_req <= 1'b1;
        snap(PMS_ACTIVE, 1'b1, 1'b0, 4'h4, 1'b0);
        bb_tx_req <= 1'b0;
        bb_rx_req <= 1'b1;
        snap(PMS_ACTIVE, 1'b1, 1'b0, 4'h9, 1'b0);
        bb_rx_req <= 1'b0;
        wr(PMS_OFS_RF_FORCE, 32'h1);
        snap(PMS_ACTIVE, 1'b1, 1'b0, 4'hE, 1'b0);
        wr(PMS_OFS_RF_FORCE, 32'h0);
        wr(PMS_OFS_CMD, 32'h2);
        rd(PMS_OFS_STATUS, 32'h1);
        wr(PMS_OFS_CMD, 32'h1);
        rd(PMS_OFS_STATUS, 32'h0);
        wr(PMS_OFS_LP_IVL, 32'h2);
        wr(PMS_OFS_CTRL, 32'h4);
        wr(PMS_OFS_CMD, 32'h2);
        wr(PMS_OFS_CMD, 32'h2);
        rd(PMS_OFS_STATUS, 32'h2);
        wr(PMS_OFS_IRQ_CLR, 32'h7);
        lp_run <= 1'b1;
        wait_mode(PMS_ACTIVE);
        lp_run <= 1'b0;
        rd(PMS_OFS_IRQ_STAT, 32'h5);
        rd(PMS_OFS_TIMER, 32'h0);
        // Frozen block must not take the step command
        clk_en <= 1'b0;
        wr(PMS_OFS_CMD, 32'h2);
        clk_en <= 1'b1;
        rd(PMS_OFS_STATUS, 32'h0);
        `CHK("lp_wake_tick", 32'd1, n_lpw)
        results();
    end
endmodule
